// ---- logic/uibk_pkg.sv ----
// constants of the interrupt enable bank: register offsets, bit layouts,
// implemented-bit masks, reset values and the low-power enable masks.
// assumes an 8-bit register port and a single 25 MHz chip clock.
package uibk_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // enable register offsets
    localparam logic [7:0] OFF_MAIN_EN = 8'h10;
    localparam logic [7:0] OFF_EPG_EN  = 8'h11;
    localparam logic [7:0] OFF_SIE_EN  = 8'h12;
    localparam logic [7:0] OFF_CPU_EN  = 8'h13;
    localparam logic [7:0] OFF_FIFO_EN = 8'h14;
    localparam logic [7:0] OFF_BULK_EN = 8'h15;
    localparam logic [7:0] OFF_IDE_EN  = 8'h16;

    // status offsets; status of a group clears by writing 1
    localparam logic [7:0] OFF_MAIN_ST = 8'h00;
    localparam logic [7:0] OFF_EPG_ST  = 8'h01;
    localparam logic [7:0] OFF_SIE_ST  = 8'h02;
    localparam logic [7:0] OFF_CPU_ST  = 8'h03;
    localparam logic [7:0] OFF_FIFO_ST = 8'h04;
    localparam logic [7:0] OFF_BULK_ST = 8'h05;
    localparam logic [7:0] OFF_IDE_ST  = 8'h06;

    // main status / main enable bit positions
    localparam int MB_SIE   = 7;
    localparam int MB_EPG   = 6;
    localparam int MB_CPU   = 5;
    localparam int MB_FIFO  = 4;
    localparam int MB_BULK  = 3;
    localparam int MB_IDE   = 2;
    localparam int MB_EP0   = 1;
    localparam int MB_SETUP = 0;

    // implemented bits of each enable register
    localparam logic [7:0] MASK_MAIN = 8'hFF;
    localparam logic [7:0] MASK_EPG  = 8'h07;
    localparam logic [7:0] MASK_SIE  = 8'hFF;
    localparam logic [7:0] MASK_CPU  = 8'h73;
    localparam logic [7:0] MASK_FIFO = 8'hFD;
    localparam logic [7:0] MASK_BULK = 8'hEC;
    localparam logic [7:0] MASK_IDE  = 8'hF7;

    // serial engine: bus power 7, non-idle 6, power mgmt done 5,
    // reset detect 4, suspend detect 3, handshake 2, restore 1, address 0
    localparam logic [7:0] MASK_SIE_SYNC  = 8'h1F;
    localparam logic [7:0] SLEEP_MAIN     = 8'h80;
    localparam logic [7:0] SLEEP_SIE      = 8'hE0;

    localparam logic [7:0] RST_EN = 8'h00;
    localparam logic [7:0] RST_ST = 8'h00;
endpackage : uibk_pkg

// ---- logic/uibk_group.sv ----
// one cause group: sticky cause bits, write-one clear, enable gating
// into a single summary level.
// assumes cause pulses and the clear strobe come from the chip clock domain.
`timescale 1ns/100ps
module uibk_group #(
    parameter logic [7:0] USED_MASK = 8'hFF
) (
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       ce_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] event_i,
    input  wire logic                       clear_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] clear_data_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] enable_i,
    output logic      [uibk_pkg::DATA_W-1:0] status_o,
    output logic                            summary_o
);
    import uibk_pkg::*;

    logic [DATA_W-1:0] status_reg;
    logic [DATA_W-1:0] clr_mask;

    assign clr_mask = clear_i ? clear_data_i : '0;

    // sticky causes; a new event beats a clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            status_reg <= RST_ST;
        end else if (ce_i) begin
            status_reg <= ((status_reg & ~clr_mask) | event_i)
                          & USED_MASK;
        end
    end

    // summary is the or of enabled causes
    assign status_o  = status_reg;
    assign summary_o = |(status_reg & enable_i);

    // a new event beats a clear; a written one clears a quiet cause
    a_set_beats_clr : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && clear_i && |(event_i & clear_data_i & USED_MASK)
        |=> |(status_reg & $past(event_i & clear_data_i)))
        else $error("event lost against a clear");
    a_clear_w1c : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && clear_i && event_i == '0
        |=> (status_reg & $past(clear_data_i)) == '0)
        else $error("write one did not clear cause");
endmodule : uibk_group

// ---- logic/uibk_enable_bank.sv ----
// interrupt enable bank: main and six group enable registers, group
// status, low-power masking and the active-low interrupt output.
// assumes all inputs come from logic on the same 25 MHz clock.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
// Operation
// - irq output only for main causes whose main enable is set; main enables reset zero.
// - main enables 7..0: serial,endpoint,cpu,fifo,bulk,disk,ep0,setup.
// - serial-engine main enable still works in sleep or snooze.
// - endpoint group enable gates endpoint C,B,A on bits 2..0; rest unused.
// - serial-engine enable layout, power mgmt 5, reset 4, suspend 3.
// - bus power, non-idle, power-mgmt enables still work in sleep or snooze.
// - in full clock active state writes to serial bits 4..0 are ignored.
// - cpu enable: 6 frame start, 5/4 dma1, 1/0 dma0; 7,3,2 unused.
// - fifo enable layout with bit 1 unused.
// - bulk enable layout; bits 4,1,0 carry no function.
// - disk port enable layout with bit 3 unused.
// - status cause bits clear on writing one; zero leaves them.
module uibk_enable_bank (
    input  wire logic                        clock_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        ce_i,
    input  wire logic [uibk_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] wr_data_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [uibk_pkg::DATA_W-1:0] rd_data_o,
    output logic                             irq_out_n_o,
    input  wire logic                        low_power_i,
    input  wire logic                        full_clock_active_state_i,
    input  wire logic [2:0]                  endpoint_summary_i,
    input  wire logic                        ctrl_endpoint_group_i,
    input  wire logic                        ctrl_setup_received_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] serial_engine_event_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] cpu_dma_event_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] fifo_event_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] bulk_only_event_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] disk_port_event_i
);
    import uibk_pkg::*;

    logic [DATA_W-1:0] main_irq_enable_reg;
    logic [DATA_W-1:0] endpoint_group_irq_enable_reg;
    logic [DATA_W-1:0] serial_engine_irq_enable_reg;
    logic [DATA_W-1:0] cpu_dma_irq_enable_reg;
    logic [DATA_W-1:0] fifo_irq_enable_reg;
    logic [DATA_W-1:0] bulk_only_irq_enable_reg;
    logic [DATA_W-1:0] disk_port_irq_enable_reg;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic              irq_out_n_reg;
    logic [DATA_W-1:0] main_eff;
    logic [DATA_W-1:0] sie_eff;
    logic [DATA_W-1:0] main_irq_status;
    logic [DATA_W-1:0] sie_st;
    logic [DATA_W-1:0] cpu_st;
    logic [DATA_W-1:0] fifo_st;
    logic [DATA_W-1:0] bulk_st;
    logic [DATA_W-1:0] ide_st;
    logic              endpoint_group_summary;
    logic              serial_engine_summary;
    logic              cpu_dma_summary;
    logic              fifo_summary;
    logic              bulk_only_summary;
    logic              disk_port_summary;
    logic              irq_any;

    // write strobe for one offset
    function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
        wr_hit = ce_i && wr_i && addr_i == off;
    endfunction : wr_hit

    // new value in the masked bits, old value kept in the rest
    function automatic logic [DATA_W-1:0] keep(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [DATA_W-1:0] msk);
        keep = ((old_v & ~msk) | (new_v & msk)) & MASK_MAIN;
    endfunction : keep

    // main enable register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            main_irq_enable_reg <= RST_EN;
        end else if (wr_hit(OFF_MAIN_EN)) begin
            main_irq_enable_reg <= wr_data_i & MASK_MAIN;
        end
    end

    // group enable registers, unused bits held at zero
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            endpoint_group_irq_enable_reg <= RST_EN;
            cpu_dma_irq_enable_reg        <= RST_EN;
            fifo_irq_enable_reg           <= RST_EN;
            bulk_only_irq_enable_reg      <= RST_EN;
            disk_port_irq_enable_reg      <= RST_EN;
        end else begin
            if (wr_hit(OFF_EPG_EN)) begin
                endpoint_group_irq_enable_reg <=
                    wr_data_i & MASK_EPG;
            end
            if (wr_hit(OFF_CPU_EN)) begin
                cpu_dma_irq_enable_reg <= wr_data_i & MASK_CPU;
            end
            if (wr_hit(OFF_FIFO_EN)) begin
                fifo_irq_enable_reg <= wr_data_i & MASK_FIFO;
            end
            if (wr_hit(OFF_BULK_EN)) begin
                bulk_only_irq_enable_reg <=
                    wr_data_i & MASK_BULK;
            end
            if (wr_hit(OFF_IDE_EN)) begin
                disk_port_irq_enable_reg <=
                    wr_data_i & MASK_IDE;
            end
        end
    end

    // serial engine enable; synchronous bits locked at full clock
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            serial_engine_irq_enable_reg <= RST_EN;
        end else if (wr_hit(OFF_SIE_EN)) begin
            serial_engine_irq_enable_reg <= keep(serial_engine_irq_enable_reg,
                wr_data_i, full_clock_active_state_i
                ? (MASK_SIE & ~MASK_SIE_SYNC) : MASK_SIE);
        end
    end

    // enables that survive sleep and snooze
    assign main_eff = low_power_i ? (main_irq_enable_reg & SLEEP_MAIN)
                                  : main_irq_enable_reg;
    assign sie_eff  = low_power_i ? (serial_engine_irq_enable_reg & SLEEP_SIE)
                                  : serial_engine_irq_enable_reg;

    // endpoint group is a pure gate of the per-endpoint summaries
    assign endpoint_group_summary =
        |(endpoint_summary_i & endpoint_group_irq_enable_reg[2:0]);

    uibk_group #(.USED_MASK(MASK_SIE)) u_sie (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .event_i      (serial_engine_event_i),
        .clear_i      (wr_hit(OFF_SIE_ST)),
        .clear_data_i (wr_data_i),
        .enable_i     (sie_eff),
        .status_o     (sie_st),
        .summary_o    (serial_engine_summary)
    );
    uibk_group #(.USED_MASK(MASK_CPU)) u_cpu (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .event_i      (cpu_dma_event_i),
        .clear_i      (wr_hit(OFF_CPU_ST)),
        .clear_data_i (wr_data_i),
        .enable_i     (cpu_dma_irq_enable_reg),
        .status_o     (cpu_st),
        .summary_o    (cpu_dma_summary)
    );
    uibk_group #(.USED_MASK(MASK_FIFO)) u_fifo (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .event_i      (fifo_event_i),
        .clear_i      (wr_hit(OFF_FIFO_ST)),
        .clear_data_i (wr_data_i),
        .enable_i     (fifo_irq_enable_reg),
        .status_o     (fifo_st),
        .summary_o    (fifo_summary)
    );
    uibk_group #(.USED_MASK(MASK_BULK)) u_bulk (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .event_i      (bulk_only_event_i),
        .clear_i      (wr_hit(OFF_BULK_ST)),
        .clear_data_i (wr_data_i),
        .enable_i     (bulk_only_irq_enable_reg),
        .status_o     (bulk_st),
        .summary_o    (bulk_only_summary)
    );
    uibk_group #(.USED_MASK(MASK_IDE)) u_ide (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .event_i      (disk_port_event_i),
        .clear_i      (wr_hit(OFF_IDE_ST)),
        .clear_data_i (wr_data_i),
        .enable_i     (disk_port_irq_enable_reg),
        .status_o     (ide_st),
        .summary_o    (disk_port_summary)
    );

    // main status assembled from the group summaries
    always_comb begin
        main_irq_status           = '0;
        main_irq_status[MB_SIE]   = serial_engine_summary;
        main_irq_status[MB_EPG]   = endpoint_group_summary;
        main_irq_status[MB_CPU]   = cpu_dma_summary;
        main_irq_status[MB_FIFO]  = fifo_summary;
        main_irq_status[MB_BULK]  = bulk_only_summary;
        main_irq_status[MB_IDE]   = disk_port_summary;
        main_irq_status[MB_EP0]   = ctrl_endpoint_group_i;
        main_irq_status[MB_SETUP] = ctrl_setup_received_i;
    end

    assign irq_any = |(main_irq_status & main_eff);

    // interrupt output, active low, registered
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_out_n_reg <= 1'b1;
        end else if (ce_i) begin
            irq_out_n_reg <= !irq_any;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_data_next = '0;
        if (rd_i) begin
            unique case (addr_i)
                OFF_MAIN_EN: rd_data_next = main_irq_enable_reg;
                OFF_EPG_EN:  rd_data_next = endpoint_group_irq_enable_reg;
                OFF_SIE_EN:  rd_data_next =
                    serial_engine_irq_enable_reg;
                OFF_CPU_EN:  rd_data_next = cpu_dma_irq_enable_reg;
                OFF_FIFO_EN: rd_data_next = fifo_irq_enable_reg;
                OFF_BULK_EN: rd_data_next = bulk_only_irq_enable_reg;
                OFF_IDE_EN:  rd_data_next = disk_port_irq_enable_reg;
                OFF_MAIN_ST: rd_data_next = main_irq_status;
                OFF_EPG_ST:  rd_data_next = {5'h00, endpoint_summary_i};
                OFF_SIE_ST:  rd_data_next = sie_st;
                OFF_CPU_ST:  rd_data_next = cpu_st;
                OFF_FIFO_ST: rd_data_next = fifo_st;
                OFF_BULK_ST: rd_data_next = bulk_st;
                OFF_IDE_ST:  rd_data_next = ide_st;
                default:     rd_data_next = '0;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rd_data_reg <= '0;
        end else if (ce_i) begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data_o   = rd_data_reg;
    assign irq_out_n_o = irq_out_n_reg;

    sequence s_rd_main;
        ce_i && rd_i && addr_i == OFF_MAIN_EN;
    endsequence
    sequence s_wr_main;
        ce_i && wr_i && addr_i == OFF_MAIN_EN;
    endsequence

    // checks of reset, readback, gating and low-power masking
    a_main_reset_zero : assert property (
        @(posedge clock_i) !rst_n_i |=> main_irq_enable_reg == 8'h00)
        else $error("main enable not zero after reset");
    a_main_write_read : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        s_wr_main ##1 s_rd_main |=> rd_data_o == $past(wr_data_i, 2))
        else $error("main enable readback wrong");
    a_irq_gating : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i |=> irq_out_n_o == !$past(|(main_irq_status & main_eff)))
        else $error("interrupt output not gated by main enable");
    a_sie_sleep_irq : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && low_power_i && main_irq_enable_reg[MB_SIE]
        && serial_engine_summary |=> !irq_out_n_o)
        else $error("serial group blocked in low power");
    a_sie_sleep_mask : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        low_power_i |-> (main_eff & ~SLEEP_MAIN) == 8'h00
        && serial_engine_summary
        == |(sie_st & serial_engine_irq_enable_reg & SLEEP_SIE))
        else $error("non-wake enable active in low power");
    a_ep_gate : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && main_irq_enable_reg[MB_EPG] && !low_power_i
        && |(endpoint_summary_i & endpoint_group_irq_enable_reg[2:0])
        |=> !irq_out_n_o)
        else $error("endpoint group gating wrong");
    a_sync_lock : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        wr_hit(OFF_SIE_EN) && full_clock_active_state_i
        |=> serial_engine_irq_enable_reg[4:0]
            == $past(serial_engine_irq_enable_reg[4:0]))
        else $error("synchronous serial bits written at full clock");
    a_async_write : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        wr_hit(OFF_SIE_EN) && full_clock_active_state_i
        |=> serial_engine_irq_enable_reg[7:5] == $past(wr_data_i[7:5]))
        else $error("upper serial bits not written at full clock");
    a_unused_zero : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        (cpu_dma_irq_enable_reg & ~MASK_CPU) == 8'h00
        && (bulk_only_irq_enable_reg & ~MASK_BULK) == 8'h00
        && (fifo_irq_enable_reg & ~MASK_FIFO) == 8'h00
        && (disk_port_irq_enable_reg & ~MASK_IDE) == 8'h00
        && (endpoint_group_irq_enable_reg & ~MASK_EPG) == 8'h00)
        else $error("unused enable bit set");
    a_irq_hold : assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && irq_any ##1 ce_i && irq_any |=> !irq_out_n_o [*1])
        else $error("interrupt output dropped while cause pending");
endmodule : uibk_enable_bank

// ---- sim/uibk_host_model.sv ----
// host cpu model: single-cycle register writes and reads on the port.
// assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/100ps
module uibk_host_model (
    input  wire logic                        clock_i,
    input  wire logic [uibk_pkg::DATA_W-1:0] rd_data_i,
    output logic      [uibk_pkg::ADDR_W-1:0] addr_o,
    output logic      [uibk_pkg::DATA_W-1:0] wr_data_o,
    output logic                             wr_o,
    output logic                             rd_o
);
    import uibk_pkg::*;
    // idle bus from time zero
    initial begin
        addr_o    = 8'h00;
        wr_data_o = 8'h00;
        wr_o      = 1'b0;
        rd_o      = 1'b0;
    end
    // one write cycle; a one enables a cause or clears a status bit
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_o    <= a;
        wr_data_o <= d;
        wr_o      <= 1'b1;
        @(posedge clock_i);
        wr_o      <= 1'b0;
        wr_data_o <= ~d; // released data no longer show the value
    endtask : wr_reg
    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        @(posedge clock_i);
        addr_o    <= a;
        wr_data_o <= d;
        wr_o      <= 1'b1;
        @(posedge clock_i);
        wr_o      <= 1'b0;
        rd_o      <= 1'b1;
        @(posedge clock_i);
        rd_o      <= 1'b0;
        @(negedge clock_i);
        q = rd_data_i;
    endtask : wr_rd
    // one read cycle; data taken mid-cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clock_i);
        rd_o   <= 1'b0;
        @(negedge clock_i);
        d = rd_data_i;
    endtask : rd_reg
endmodule : uibk_host_model

// ---- sim/testbench.sv ----
// self-checking bench of the enable bank against a queue-free model.
// assumes the host model drives the register port.
`timescale 1ns/100ps
module testbench;
    import uibk_pkg::*;
    logic       clock_i, rst_n_i, ce_i, lp, fca, wr, rd, irq_n, ep0, setup;
    logic [7:0] addr, wdat, rdat;
    logic [2:0] ep;
    logic [7:0] ev [7];
    int         fails = 0;
    int         n_checks = 0;
    int         en [7];
    int         st [7];
    int unsigned seed = 63;
    logic [7:0] msk [7] = '{MASK_MAIN, MASK_EPG, MASK_SIE, MASK_CPU,
                            MASK_FIFO, MASK_BULK, MASK_IDE};

    uibk_host_model i_host (.clock_i(clock_i), .rd_data_i(rdat),
        .addr_o(addr), .wr_data_o(wdat), .wr_o(wr), .rd_o(rd));

    uibk_enable_bank i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .ce_i(ce_i), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr),
        .rd_i(rd), .rd_data_o(rdat), .irq_out_n_o(irq_n),
        .low_power_i(lp), .full_clock_active_state_i(fca),
        .endpoint_summary_i(ep), .ctrl_endpoint_group_i(ep0),
        .ctrl_setup_received_i(setup), .serial_engine_event_i(ev[2]),
        .cpu_dma_event_i(ev[3]), .fifo_event_i(ev[4]),
        .bulk_only_event_i(ev[5]), .disk_port_event_i(ev[6]));

    // free-running 25 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // xorshift source
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    // model of the main status, with the sleep masking of serial causes
    function automatic logic [7:0] main_st(input logic sleep);
        logic [7:0] m;
        logic [7:0] se;
        se = sleep ? (8'(en[2]) & SLEEP_SIE) : 8'(en[2]);
        m[7] = |(8'(st[2]) & se);
        m[6] = |(ep & en[1][2:0]);
        m[5] = |(8'(st[3] & en[3]));
        m[4] = |(8'(st[4] & en[4]));
        m[3] = |(8'(st[5] & en[5]));
        m[2] = |(8'(st[6] & en[6]));
        m[1] = ep0;
        m[0] = setup;
        return m;
    endfunction : main_st

    // expected interrupt level, active low
    function automatic logic exp_irq();
        logic [7:0] men;
        men = lp ? (8'(en[0]) & SLEEP_MAIN) : 8'(en[0]);
        return !(|(main_st(lp) & men));
    endfunction : exp_irq

    task automatic finish_test();
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %0t: read %h want %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_irq(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %0t: irq %b want %b", $time, got, exp);
        end
    endtask : chk_irq

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd_reg(a, d);
        chk_reg(d, exp);
    endtask : rd_chk

    // enable write and its model; sync serial bits locked in full clock
    task automatic wr_en(input int o, input logic [7:0] d);
        i_host.wr_reg(8'(16 + o), d);
        if (o == 2 && fca) begin
            en[2] = (d & ~MASK_SIE_SYNC) | (en[2] & MASK_SIE_SYNC);
        end else begin
            en[o] = d & msk[o];
        end
    endtask : wr_en

    task automatic wr_clr(input int g, input logic [7:0] d);
        i_host.wr_reg(8'(g), d);
        st[g] = st[g] & ~d;
    endtask : wr_clr

    // one cycle of random cause pulses on each of the five sticky groups
    task automatic pulse(input bit frz);
        logic [7:0] v;
        @(posedge clock_i);
        for (int g = 2; g < 7; g++) begin
            v = rnd();
            ev[g] <= v;
            if (!frz) st[g] |= v & msk[g];
        end
        @(posedge clock_i);
        for (int g = 2; g < 7; g++) ev[g] <= 8'h00;
    endtask : pulse

    // watchdog against a hung sequence
    initial begin
        #2000000;
        fails++;
        finish_test();
    end

    // main sequence
    initial begin
        logic [7:0] v;
        {rst_n_i, lp, fca, ep, ep0, setup} = '0;
        ce_i = 1'b1;
        for (int g = 0; g < 7; g++) begin
            ev[g] = 8'h00;
            en[g] = 0;
            st[g] = 0;
        end
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(negedge clock_i);
        chk_irq(irq_n, 1'b1);
        // reset values, then an unmapped place
        for (int o = 0; o < 7; o++) begin
            rd_chk(8'(o), 8'h00);
            rd_chk(8'(16 + o), 8'h00);
        end
        rd_chk(8'h20, 8'h00);
        // all ones then random into each enable
        for (int o = 0; o < 7; o++) begin
            for (int k = 0; k < 2; k++) begin
                wr_en(o, k ? rnd() : 8'hFF);
                rd_chk(8'(16 + o), 8'(en[o]));
            end
        end
        @(posedge clock_i);
        fca <= 1'b1;
        wr_en(2, ~en[2][7:0]);
        rd_chk(8'h12, 8'(en[2]));
        @(posedge clock_i);
        fca <= 1'b0;
        i_host.wr_reg(8'h30, 8'hFF);
        rd_chk(OFF_MAIN_EN, 8'(en[0]));
        i_host.wr_rd(OFF_MAIN_EN, 8'h5A, v);
        en[0] = 8'h5A;
        chk_reg(v, 8'h5A);
        // random enables, causes, sleep and clears
        for (int i = 0; i < 48; i++) begin
            for (int o = 0; o < 7; o++) wr_en(o, rnd());
            v = rnd();
            @(posedge clock_i);
            lp <= &v[7:6];
            ep <= v[3:1];
            ep0 <= v[4];
            setup <= v[5];
            pulse(1'b0);
            repeat (3) @(posedge clock_i);
            @(negedge clock_i);
            chk_irq(irq_n, exp_irq());
            rd_chk(OFF_MAIN_ST, main_st(lp));
            rd_chk(OFF_EPG_ST, {5'h00, ep});
            for (int g = 2; g < 7; g++) begin
                rd_chk(8'(g), 8'(st[g]));
                wr_clr(g, rnd());
            end
            repeat (3) @(posedge clock_i);
            @(negedge clock_i);
            chk_irq(irq_n, exp_irq());
        end
        // event and clear in one cycle: the event is kept
        st[4] = 0;
        fork
            i_host.wr_reg(OFF_FIFO_ST, 8'hFF);
            pulse(1'b0);
        join
        rd_chk(OFF_FIFO_ST, 8'(st[4]));
        // frozen clock enable ignores causes
        @(posedge clock_i);
        ce_i <= 1'b0;
        pulse(1'b1);
        @(posedge clock_i);
        ce_i <= 1'b1;
        for (int g = 2; g < 7; g++) rd_chk(8'(g), 8'(st[g]));
        // reset in mid-run; irq, main enable and fifo status are checked back at their reset values
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int g = 0; g < 7; g++) begin
            en[g] = 0;
            st[g] = 0;
        end
        @(negedge clock_i);
        chk_irq(irq_n, 1'b1);
        rd_chk(OFF_MAIN_EN, 8'h00);
        rd_chk(OFF_FIFO_ST, 8'h00);
        finish_test();
    end
endmodule : testbench
